// File: hdl/motion_flags_pkg.sv
package motion_flags_pkg;

	// ------------------------------------------------------------
	// Register map (word index on the plain register port)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_COND_SELECT   = 4'h0;
	localparam logic [3:0] ADDR_COMPLETE_THR  = 4'h1;
	localparam logic [3:0] ADDR_APPROACH_THR  = 4'h2;
	localparam logic [3:0] ADDR_WINDOW_TIME   = 4'h3;
	localparam logic [3:0] ADDR_HOLD_TIME     = 4'h4;
	localparam logic [3:0] ADDR_ROTATION_THR  = 4'h5;
	localparam logic [3:0] ADDR_MATCH_THR     = 4'h6;
	localparam logic [3:0] ADDR_NEAR_THR      = 4'h7;
	localparam logic [3:0] ADDR_STANDSTILL    = 4'h8;
	localparam logic [3:0] ADDR_TORQUE_THR    = 4'h9;
	localparam logic [3:0] ADDR_TORQUE_HYST   = 4'ha;
	localparam logic [3:0] ADDR_FLAGS         = 4'hb;
	localparam logic [3:0] ADDR_IRQ_STATUS    = 4'hc;
	localparam logic [3:0] ADDR_IRQ_MASK      = 4'hd;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [1:0]  RST_COND_SELECT  = 2'h0;
	localparam logic [15:0] RST_COMPLETE_THR = 16'h0320;
	localparam logic [15:0] RST_APPROACH_THR = 16'h1388;
	localparam logic [15:0] RST_WINDOW_TIME  = 16'h000a;
	localparam logic [15:0] RST_HOLD_TIME    = 16'h0064;
	localparam logic [15:0] RST_ROTATION_THR = 16'h0014;
	localparam logic [15:0] RST_MATCH_THR    = 16'h000a;
	localparam logic [15:0] RST_NEAR_THR     = 16'h0064;
	localparam logic [15:0] RST_STANDSTILL   = 16'h000a;
	localparam logic [15:0] RST_TORQUE_THR   = 16'h0064;
	localparam logic [15:0] RST_TORQUE_HYST  = 16'h000a;
	localparam logic [6:0]  RST_IRQ_MASK     = 7'h00;

	// ------------------------------------------------------------
	// Selector codes and timing
	// ------------------------------------------------------------
	localparam logic [1:0] COND_THRESHOLD  = 2'h0;
	localparam logic [1:0] COND_CMD_ZERO   = 2'h1;
	localparam logic [1:0] COND_FILT_ZERO  = 2'h2;
	localparam logic [1:0] COND_WINDOWED   = 2'h3;
	localparam int CLK_HZ      = 10_000_000;
	localparam int TICK_MS     = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

	typedef struct packed {
		logic torque_reached;
		logic standstill;
		logic speed_near;
		logic speed_match;
		logic motor_rotating;
		logic positioning_complete;
		logic positioning_approach;
	} flags_type;

endpackage

// File: hdl/motion_status_flag_generator.sv
// Overview of operation
// RL1: Position mode: approach flag when deviation within approach threshold.
// RL2: Detection window time in ms, default 10, qualifies completion.
// RL3: Selector 3: completion flag held for hold time after positioning.
// RL4: Rotating flag when absolute speed reaches rotation threshold.
// RL5: Match flag when commanded minus actual speed within threshold.
// RL6: Near flag when actual speed within threshold of expected value.
// RL7: Standstill flag when absolute speed below threshold, default 10.
// RL8: Torque reached flag from percent threshold, default 100.
// RL9: Torque hysteresis, default 10, stops the flag chattering.
// RL10: Position mode: completion flag when deviation within threshold.
// RL11: Selector adds qualifiers: none, zero command, zero filtered command.
// RL12: Selector 3 also needs condition held for the detection window.
// RL13: Millisecond tick from clk_sys times window and hold durations.
// RL14: Absolute speed compared each cycle; every flag updated synchronously.
`timescale 1ns/1ps
module motion_status_flag_generator
#(
	parameter int TICK_CYCLES = motion_flags_pkg::TICK_CYCLES
)
(
	input  wire logic                         clk_sys,
	input  wire logic                         rst_n,
	input  wire logic                         clk_en,
	input  wire logic [3:0]                   reg_addr,
	input  wire logic [15:0]                  reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [15:0]                  reg_rdata,
	input  wire logic                         position_mode,
	input  wire logic signed [31:0]           position_deviation,
	input  wire logic                         position_cmd_zero,
	input  wire logic                         filtered_cmd_zero,
	input  wire logic signed [15:0]           speed_actual,
	input  wire logic signed [15:0]           speed_command,
	input  wire logic signed [15:0]           speed_expected,
	input  wire logic [15:0]                  torque_percent,
	output motion_flags_pkg::flags_type       flags,
	output logic                              irq
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [1:0]  sel_reg, sel_next;
	logic [15:0] cthr_reg, cthr_next, athr_reg, athr_next;
	logic [15:0] win_reg, win_next, hold_reg, hold_next;
	logic [15:0] rot_reg, rot_next, mat_reg, mat_next;
	logic [15:0] near_reg, near_next, zsp_reg, zsp_next;
	logic [15:0] tq_reg, tq_next, hys_reg, hys_next;
	logic [6:0]  stat_reg, stat_next, mask_reg, mask_next;
	logic [15:0] rdata_reg, rdata_next;
	logic        irq_reg, irq_next;
	logic [23:0] tick_cnt_reg, tick_cnt_next;
	logic        tick;
	logic [15:0] win_cnt_reg, win_cnt_next, hold_cnt_reg, hold_cnt_next;
	motion_flags_pkg::flags_type flags_reg, flags_next;

	logic [31:0] abs_dev;
	logic [15:0] abs_spd, abs_diff, abs_near;
	logic        base_ok, cond_ok;
	logic [16:0] tq_low;

	always_comb
	begin
		abs_dev  = position_deviation[31] ? 32'(-position_deviation)
			: 32'(position_deviation);
		abs_spd  = speed_actual[15] ? 16'(-speed_actual) : 16'(speed_actual);
		abs_diff = 16'(speed_command - speed_actual);
		if (abs_diff[15])
			abs_diff = 16'(-abs_diff);
		abs_near = 16'(speed_expected - speed_actual);
		if (abs_near[15])
			abs_near = 16'(-abs_near);
		tq_low = {1'b0, tq_reg} - {1'b0, hys_reg};
	end

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	always_comb
	begin
		sel_next  = sel_reg;
		cthr_next = cthr_reg;
		athr_next = athr_reg;
		win_next  = win_reg;
		hold_next = hold_reg;
		rot_next  = rot_reg;
		mat_next  = mat_reg;
		near_next = near_reg;
		zsp_next  = zsp_reg;
		tq_next   = tq_reg;
		hys_next  = hys_reg;
		mask_next = mask_reg;
		rdata_next = 16'h0000;
		if (reg_wr)
		begin
			unique case (reg_addr)
				motion_flags_pkg::ADDR_COND_SELECT:  sel_next  = reg_wdata[1:0];
				motion_flags_pkg::ADDR_COMPLETE_THR: cthr_next = reg_wdata;
				motion_flags_pkg::ADDR_APPROACH_THR: athr_next = reg_wdata;
				motion_flags_pkg::ADDR_WINDOW_TIME:  win_next  = reg_wdata;
				motion_flags_pkg::ADDR_HOLD_TIME:    hold_next = reg_wdata;
				motion_flags_pkg::ADDR_ROTATION_THR: rot_next  = reg_wdata;
				motion_flags_pkg::ADDR_MATCH_THR:    mat_next  = reg_wdata;
				motion_flags_pkg::ADDR_NEAR_THR:     near_next = reg_wdata;
				motion_flags_pkg::ADDR_STANDSTILL:   zsp_next  = reg_wdata;
				motion_flags_pkg::ADDR_TORQUE_THR:   tq_next   = reg_wdata;
				motion_flags_pkg::ADDR_TORQUE_HYST:  hys_next  = reg_wdata;
				motion_flags_pkg::ADDR_IRQ_MASK:     mask_next = reg_wdata[6:0];
				default: ;
			endcase
		end
		if (reg_rd)
		begin
			unique case (reg_addr)
				motion_flags_pkg::ADDR_COND_SELECT:  rdata_next = {14'h0000, sel_reg};
				motion_flags_pkg::ADDR_COMPLETE_THR: rdata_next = cthr_reg;
				motion_flags_pkg::ADDR_APPROACH_THR: rdata_next = athr_reg;
				motion_flags_pkg::ADDR_WINDOW_TIME:  rdata_next = win_reg;
				motion_flags_pkg::ADDR_HOLD_TIME:    rdata_next = hold_reg;
				motion_flags_pkg::ADDR_ROTATION_THR: rdata_next = rot_reg;
				motion_flags_pkg::ADDR_MATCH_THR:    rdata_next = mat_reg;
				motion_flags_pkg::ADDR_NEAR_THR:     rdata_next = near_reg;
				motion_flags_pkg::ADDR_STANDSTILL:   rdata_next = zsp_reg;
				motion_flags_pkg::ADDR_TORQUE_THR:   rdata_next = tq_reg;
				motion_flags_pkg::ADDR_TORQUE_HYST:  rdata_next = hys_reg;
				motion_flags_pkg::ADDR_FLAGS:        rdata_next = {9'h000, flags_reg};
				motion_flags_pkg::ADDR_IRQ_STATUS:   rdata_next = {9'h000, stat_reg};
				motion_flags_pkg::ADDR_IRQ_MASK:     rdata_next = {9'h000, mask_reg};
				default:                             rdata_next = 16'h0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Tick and window timing
	// ------------------------------------------------------------
	assign tick = (tick_cnt_reg == 24'(TICK_CYCLES - 1)); // RL13

	always_comb
	begin
		tick_cnt_next = tick ? 24'h000000 : tick_cnt_reg + 24'h000001; // RL13
		base_ok = position_mode && (abs_dev <= {16'h0000, cthr_reg}); // RL10
		unique case (sel_reg) // RL11
			motion_flags_pkg::COND_THRESHOLD: cond_ok = base_ok;
			motion_flags_pkg::COND_CMD_ZERO:  cond_ok = base_ok && position_cmd_zero;
			default:                          cond_ok = base_ok && filtered_cmd_zero;
		endcase
		// Window counter restarts the moment the condition drops
		win_cnt_next = win_cnt_reg;
		if (!cond_ok)
			win_cnt_next = 16'h0000; // RL12
		else if (tick && win_cnt_reg < win_reg)
			win_cnt_next = win_cnt_reg + 16'h0001; // RL2
		hold_cnt_next = hold_cnt_reg;
		if (cond_ok && win_cnt_reg >= win_reg)
			hold_cnt_next = hold_reg; // RL3
		else if (tick && hold_cnt_reg != 16'h0000)
			hold_cnt_next = hold_cnt_reg - 16'h0001; // RL3
	end

	// ------------------------------------------------------------
	// Flag generation
	// ------------------------------------------------------------
	always_comb
	begin
		flags_next = flags_reg;
		flags_next.positioning_approach = position_mode
			&& (abs_dev <= {16'h0000, athr_reg}); // RL1
		if (sel_reg == motion_flags_pkg::COND_WINDOWED)
			flags_next.positioning_complete = (cond_ok && win_cnt_reg >= win_reg)
				|| (hold_cnt_reg != 16'h0000); // RL12 RL3
		else
			flags_next.positioning_complete = cond_ok; // RL11
		flags_next.motor_rotating = abs_spd >= rot_reg; // RL4 RL14
		flags_next.speed_match    = abs_diff <= mat_reg; // RL5 RL14
		flags_next.speed_near     = abs_near <= near_reg; // RL6
		flags_next.standstill     = abs_spd < zsp_reg; // RL7
		// Hysteresis band: set at threshold, clear below threshold minus band
		if ({1'b0, torque_percent} >= {1'b0, tq_reg})
			flags_next.torque_reached = 1'b1; // RL8
		else if (tq_low[16] || {1'b0, torque_percent} < tq_low)
			flags_next.torque_reached = 1'b0; // RL9
		// Rising edges set status; set wins over the read clear
		stat_next = stat_reg;
		if (reg_rd && reg_addr == motion_flags_pkg::ADDR_IRQ_STATUS)
			stat_next = 7'h00;
		stat_next = stat_next | (flags_next & ~flags_reg);
		irq_next = |(stat_next & mask_next);
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			sel_reg      <= motion_flags_pkg::RST_COND_SELECT;
			cthr_reg     <= motion_flags_pkg::RST_COMPLETE_THR;
			athr_reg     <= motion_flags_pkg::RST_APPROACH_THR;
			win_reg      <= motion_flags_pkg::RST_WINDOW_TIME;
			hold_reg     <= motion_flags_pkg::RST_HOLD_TIME;
			rot_reg      <= motion_flags_pkg::RST_ROTATION_THR;
			mat_reg      <= motion_flags_pkg::RST_MATCH_THR;
			near_reg     <= motion_flags_pkg::RST_NEAR_THR;
			zsp_reg      <= motion_flags_pkg::RST_STANDSTILL;
			tq_reg       <= motion_flags_pkg::RST_TORQUE_THR;
			hys_reg      <= motion_flags_pkg::RST_TORQUE_HYST;
			mask_reg     <= motion_flags_pkg::RST_IRQ_MASK;
			stat_reg     <= 7'h00;
			rdata_reg    <= 16'h0000;
			irq_reg      <= 1'b0;
			tick_cnt_reg <= 24'h000000;
			win_cnt_reg  <= 16'h0000;
			hold_cnt_reg <= 16'h0000;
			flags_reg    <= '0;
		end
		else if (clk_en)
		begin
			sel_reg      <= sel_next;
			cthr_reg     <= cthr_next;
			athr_reg     <= athr_next;
			win_reg      <= win_next;
			hold_reg     <= hold_next;
			rot_reg      <= rot_next;
			mat_reg      <= mat_next;
			near_reg     <= near_next;
			zsp_reg      <= zsp_next;
			tq_reg       <= tq_next;
			hys_reg      <= hys_next;
			mask_reg     <= mask_next;
			stat_reg     <= stat_next;
			rdata_reg    <= rdata_next;
			irq_reg      <= irq_next;
			tick_cnt_reg <= tick_cnt_next;
			win_cnt_reg  <= win_cnt_next;
			hold_cnt_reg <= hold_cnt_next;
			flags_reg    <= flags_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign flags     = flags_reg;
	assign irq       = irq_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Attempt from a reset or frozen cycle sees no update an edge later
	logic live_reg;

	always_ff @(posedge clk_sys)
	begin
		live_reg <= rst_n && clk_en;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n || !clk_en || !live_reg);

	approach_flag_a: assert property ( // RL1
		position_mode && abs_dev <= 32'(athr_reg)
		|=> flags_reg.positioning_approach)
		else $error("approach missing");
	approach_clear_a: assert property ( // RL1
		!position_mode |=> !flags_reg.positioning_approach)
		else $error("approach outside position mode");
	tick_period_a: assert property ( // RL13
		tick |=> !tick)
		else $error("tick width");
	rotating_flag_a: assert property ( // RL4
		abs_spd >= rot_reg |=> flags_reg.motor_rotating)
		else $error("rotating missing");
	rotating_clear_a: assert property ( // RL4
		abs_spd < rot_reg |=> !flags_reg.motor_rotating)
		else $error("rotating stuck");
	match_flag_a: assert property ( // RL5
		abs_diff <= mat_reg |=> flags_reg.speed_match)
		else $error("match missing");
	match_clear_a: assert property ( // RL5
		abs_diff > mat_reg |=> !flags_reg.speed_match)
		else $error("match stuck");
	near_flag_a: assert property ( // RL6
		abs_near > near_reg |=> !flags_reg.speed_near)
		else $error("near wrong");
	standstill_flag_a: assert property ( // RL7
		abs_spd < zsp_reg |=> flags_reg.standstill)
		else $error("standstill missing");
	standstill_clear_a: assert property ( // RL7
		abs_spd >= zsp_reg |=> !flags_reg.standstill)
		else $error("standstill stuck");
	torque_set_a: assert property ( // RL8
		torque_percent >= tq_reg |=> flags_reg.torque_reached)
		else $error("torque missing");
	torque_hold_a: assert property ( // RL9
		flags_reg.torque_reached && !tq_low[16]
		&& torque_percent >= 16'(tq_low)
		|=> flags_reg.torque_reached)
		else $error("torque chatter");
	torque_clear_a: assert property ( // RL9
		!tq_low[16] && torque_percent < 16'(tq_low)
		|=> !flags_reg.torque_reached)
		else $error("torque stuck");
	complete_plain_a: assert property ( // RL10
		sel_reg == motion_flags_pkg::COND_THRESHOLD && !reg_wr
		|=> flags_reg.positioning_complete == $past(base_ok))
		else $error("completion wrong");
	window_block_a: assert property ( // RL12
		sel_reg == motion_flags_pkg::COND_WINDOWED
		&& !cond_ok && hold_cnt_reg == 16'h0000
		|=> !flags_reg.positioning_complete)
		else $error("window ignored");
	hold_keep_a: assert property ( // RL3
		sel_reg == motion_flags_pkg::COND_WINDOWED
		&& hold_cnt_reg != 16'h0000
		|=> flags_reg.positioning_complete)
		else $error("hold dropped");

	window_cov_c: cover property (sel_reg == motion_flags_pkg::COND_WINDOWED
		&& flags_reg.positioning_complete);
	hold_cov_c: cover property (hold_cnt_reg != 16'h0000 && !cond_ok);
	irq_cov_c: cover property (irq_reg);
	torque_cov_c: cover property (flags_reg.torque_reached
		&& torque_percent < tq_reg);
	standstill_cov_c: cover property (flags_reg.standstill
		&& flags_reg.speed_match);

endmodule

// File: verif/host_flag_reader.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host side: scans the drive outputs once a cycle
// ------------------------------------------------------------
module host_flag_reader
(
	input  wire logic                        clk_sys,
	input  wire logic                        rst_n,
	input  wire motion_flags_pkg::flags_type flags,
	input  wire logic                        irq,
	output motion_flags_pkg::flags_type      seen_flags,
	output logic                             seen_irq
);
	// One cycle of scan lag, as a real controller input stage
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			seen_flags <= '0;
			seen_irq   <= 1'b0;
		end
		else
		begin
			seen_flags <= flags;
			seen_irq   <= irq;
		end
	end
endmodule

// File: verif/motion_status_flag_generator_tb.sv
`timescale 1ns/1ps
module motion_status_flag_generator_tb;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic                        clk_sys = 1'b0;
	logic                        rst_n   = 1'b0;
	logic                        ena     = 1'b1;
	logic [3:0]                  reg_addr = 4'h0;
	logic [15:0]                 reg_wdata = 16'h0000;
	logic                        reg_wr = 1'b0;
	logic                        reg_rd = 1'b0;
	logic [15:0]                 reg_rdata;
	logic                        pmode = 1'b0;
	logic signed [31:0]          pdev = 32'sh0;
	logic                        cmdz = 1'b0;
	logic                        filtz = 1'b0;
	logic signed [15:0]          sact = 16'sh0;
	logic signed [15:0]          scmd = 16'sh0;
	logic signed [15:0]          sexp = 16'sh0;
	logic [15:0]                 torque = 16'h0000;
	motion_flags_pkg::flags_type flags;
	motion_flags_pkg::flags_type seen;
	logic                        irq;
	logic                        seen_irq;
	logic [15:0]                 tmp;
	int                          miscompares = 0;
	int                          checked = 0;
	int                          cycles = 0;
	logic [15:0]                 rv [11] = '{16'h0000,
		motion_flags_pkg::RST_COMPLETE_THR, motion_flags_pkg::RST_APPROACH_THR,
		motion_flags_pkg::RST_WINDOW_TIME, motion_flags_pkg::RST_HOLD_TIME,
		motion_flags_pkg::RST_ROTATION_THR, motion_flags_pkg::RST_MATCH_THR,
		motion_flags_pkg::RST_NEAR_THR, motion_flags_pkg::RST_STANDSTILL,
		motion_flags_pkg::RST_TORQUE_THR, motion_flags_pkg::RST_TORQUE_HYST};

	always #50 clk_sys = ~clk_sys;

	// Short tick keeps millisecond timing cheap: 1 ms = 10 cycles
	motion_status_flag_generator #(.TICK_CYCLES(10)) DUT (.clk_sys(clk_sys),
		.rst_n(rst_n), .clk_en(ena), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .position_mode(pmode),
		.position_deviation(pdev), .position_cmd_zero(cmdz),
		.filtered_cmd_zero(filtz), .speed_actual(sact),
		.speed_command(scmd), .speed_expected(sexp),
		.torque_percent(torque), .flags(flags), .irq(irq));

	host_flag_reader host (.clk_sys(clk_sys), .rst_n(rst_n), .flags(flags),
		.irq(irq), .seen_flags(seen), .seen_irq(seen_irq));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic finish_test();
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: read %h, want %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: flag %b, want %b", $time, got, exp);
		end
	endtask

	task automatic go(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
		logic [15:0] d;
		rd(a, d);
		chk16(d, exp);
	endtask

	task automatic spd(input logic signed [15:0] a, c, e,
		input logic rot, mat, nea, sta);
		@(posedge clk_sys);
		sact <= a;
		scmd <= c;
		sexp <= e;
		go(3);
		chk1(seen.motor_rotating, rot);
		chk1(seen.speed_match, mat);
		chk1(seen.speed_near, nea);
		chk1(seen.standstill, sta);
	endtask

	task automatic trq(input logic [15:0] v, input logic exp);
		@(posedge clk_sys);
		torque <= v;
		go(3);
		chk1(seen.torque_reached, exp);
	endtask

	task automatic pos(input logic m, input logic signed [31:0] d,
		input logic cz, fz, appr, comp);
		@(posedge clk_sys);
		pmode <= m;
		pdev  <= d;
		cmdz  <= cz;
		filtz <= fz;
		go(3);
		chk1(seen.positioning_approach, appr);
		chk1(seen.positioning_complete, comp);
	endtask

	// Hang guard: whole run needs well under 2000 cycles
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			finish_test();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int i = 0; i < 11; i++)
			rdchk(4'(i), rv[i]);
		rdchk(motion_flags_pkg::ADDR_IRQ_MASK, 16'h0000);
		wr(4'he, 16'h1234);
		rdchk(4'he, 16'h0000);
		wr(motion_flags_pkg::ADDR_WINDOW_TIME, 16'h4e20);
		rdchk(motion_flags_pkg::ADDR_WINDOW_TIME, 16'h4e20);
		spd(-16'sd20, -16'sd15, -16'sd120, 1'b1, 1'b1, 1'b1, 1'b0);
		spd(16'sd9, 16'sd20, 16'sd110, 1'b0, 1'b0, 1'b0, 1'b1);
		spd(16'sd10, 16'sd0, 16'sd110, 1'b0, 1'b1, 1'b1, 1'b0);
		wr(motion_flags_pkg::ADDR_ROTATION_THR, 16'h0005);
		spd(16'sd10, 16'sd0, 16'sd110, 1'b1, 1'b1, 1'b1, 1'b0);
		trq(16'h0064, 1'b1);
		trq(16'h005a, 1'b1);
		trq(16'h0059, 1'b0);
		trq(16'h0063, 1'b0);
		trq(16'h012c, 1'b1);
		pos(1'b1, -32'sd5000, 1'b0, 1'b0, 1'b1, 1'b0);
		pos(1'b1, 32'sd5001, 1'b0, 1'b0, 1'b0, 1'b0);
		pos(1'b1, -32'sd800, 1'b0, 1'b0, 1'b1, 1'b1);
		pos(1'b0, 32'sd0, 1'b1, 1'b1, 1'b0, 1'b0);
		wr(motion_flags_pkg::ADDR_COND_SELECT, 16'h0001);
		pos(1'b1, 32'sd0, 1'b0, 1'b1, 1'b1, 1'b0);
		pos(1'b1, 32'sd0, 1'b1, 1'b0, 1'b1, 1'b1);
		wr(motion_flags_pkg::ADDR_COND_SELECT, 16'h0002);
		pos(1'b1, 32'sd0, 1'b1, 1'b0, 1'b1, 1'b0);
		pos(1'b1, 32'sd0, 1'b0, 1'b1, 1'b1, 1'b1);
		pos(1'b1, 32'sd30000, 1'b0, 1'b1, 1'b0, 1'b0);
		wr(motion_flags_pkg::ADDR_WINDOW_TIME, 16'h0002);
		wr(motion_flags_pkg::ADDR_HOLD_TIME, 16'h0003);
		wr(motion_flags_pkg::ADDR_COND_SELECT, 16'h0003);
		pos(1'b1, 32'sd0, 1'b0, 1'b1, 1'b1, 1'b0);
		go(40);
		chk1(seen.positioning_complete, 1'b1);
		pos(1'b1, 32'sd30000, 1'b0, 1'b1, 1'b0, 1'b1);
		go(60);
		chk1(seen.positioning_complete, 1'b0);
		// Interrupt: masked event first, then unmask, then clear by read
		rd(motion_flags_pkg::ADDR_IRQ_STATUS, tmp);
		trq(16'h0000, 1'b0);
		rd(motion_flags_pkg::ADDR_IRQ_STATUS, tmp);
		trq(16'h0096, 1'b1);
		chk1(seen_irq, 1'b0);
		wr(motion_flags_pkg::ADDR_IRQ_MASK, 16'h0040);
		go(3);
		chk1(seen_irq, 1'b1);
		rdchk(motion_flags_pkg::ADDR_IRQ_STATUS, 16'h0040);
		go(3);
		chk1(seen_irq, 1'b0);
		rdchk(motion_flags_pkg::ADDR_IRQ_STATUS, 16'h0000);
		wr(motion_flags_pkg::ADDR_FLAGS, 16'h007f);
		rdchk(motion_flags_pkg::ADDR_FLAGS, 16'h005c);
		// Clock enable low: torque input moves but every flag stays put
		@(posedge clk_sys);
		ena    <= 1'b0;
		torque <= 16'h0000;
		go(3);
		chk1(seen.torque_reached, 1'b1);
		@(posedge clk_sys);
		ena <= 1'b1;
		go(3);
		chk1(seen.torque_reached, 1'b0);
		finish_test();
	end
endmodule
